// *** design/dwell_timer.v ***
`timescale 1ns/1ns
`default_nettype none

// Counts base ticks while a frequency stays in its limit band
module dwell_timer
#(
   parameter W = 17
)
(
   input  wire         aclk,
   input  wire         aresetn,
   input  wire         clear,
   input  wire         in_band,
   input  wire         tick,
   input  wire [W-1:0] limit,
   output reg          done_r
);

   reg [W-1:0] cnt_r;   // Ticks spent in band

   // -----------------------------------------
   // Dwell counter
   // -----------------------------------------
   // Leaving the band restarts the count, so only an unbroken stay counts
   always @(posedge aclk)
   begin
      if (!aresetn || clear || !in_band)
      begin
         cnt_r  <= {W{1'b0}};
         done_r <= 1'b0;
      end
      else if (done_r)
      begin
         done_r <= 1'b1;        // Hold until cleared, reset or out of band
      end
      else if (tick)
      begin
         cnt_r  <= cnt_r + {{(W-1){1'b0}}, 1'b1};
         done_r <= (cnt_r + {{(W-1){1'b0}}, 1'b1}) >= limit;
      end
   end

endmodule

`default_nettype wire

// *** design/pump_staging.v ***
`timescale 1ns/1ns
`default_nettype none
`include "staging_map.vh"

module pump_staging
#(
   parameter TICK_CYCLES = `TICK_NS / `CLK_NS,
   parameter FW          = 16
)
(
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [7:0]    awaddr,
   input  wire          awvalid,
   output reg           awready,
   input  wire [31:0]   wdata,
   input  wire [3:0]    wstrb,
   input  wire          wvalid,
   output reg           wready,
   output reg  [1:0]    bresp,
   output reg           bvalid,
   input  wire          bready,
   input  wire [7:0]    araddr,
   input  wire          arvalid,
   output reg           arready,
   output reg  [31:0]   rdata,
   output reg  [1:0]    rresp,
   output reg           rvalid,
   input  wire          rready,
   input  wire [FW-1:0] fout,
   input  wire [FW-1:0] upper_lim,
   input  wire [FW-1:0] lower_lim,
   input  wire          run_cmd,
   input  wire          card_present,
   input  wire [2:0]    gen_relay_func,
   output reg  [7:0]    card_relay,
   output reg           board_relay_out_one,
   output reg           board_relay_out_two,
   output reg           board_relay_out_three,
   output reg           inv_out_en,
   output reg           pid_hold,
   output reg           ramp_up,
   output reg           ramp_down
);

   // -----------------------------------------
   // States
   // -----------------------------------------
   localparam S_IDLE = 3'h0;
   localparam S_RUN  = 3'h1;
   localparam S_RLO  = 3'h2;   // Ramp to lower limit, loop held
   localparam S_RHI  = 3'h3;   // Ramp to upper limit, loop held
   localparam S_XOFF = 3'h4;   // Inverter off, contactor wait
   localparam S_XON  = 3'h5;   // Relays moved, contactor wait

   // -----------------------------------------
   // Registers and state
   // -----------------------------------------
   reg  [2:0]  mode_r;         // Staging mode
   reg         src_r;          // Relay source
   reg  [3:0]  en24_r;         // Relays 2-4 enables, bit 0 reserved
   reg  [3:0]  en58_r;         // Relays 5-8 enables
   reg  [15:0] up_t_r;         // Upper dwell, 0.1 s
   reg  [15:0] lo_t_r;         // Lower dwell, 0.1 s
   reg  [15:0] mc_t_r;         // Contactor delay, 0.01 s
   reg  [15:0] bias_r;         // Bias, 0.1 %
   reg  [2:0]  st_r;           // Sequencer state
   reg  [7:0]  stage_r;        // Staging relays, bit 0 is relay one
   reg  [1:0]  cur_r;          // Pair on inverter in card cycle
   reg  [16:0] wait_r;         // Contactor wait, ticks left
   reg  [21:0] tick_cnt_r;     // Base tick divider
   reg         tick_r;         // 10 ms tick
   reg         aw_full_r;      // Write address held
   reg         w_full_r;       // Write data held
   reg  [7:0]  aw_addr_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   reg         card_s1_r;      // Card pin synchroniser
   reg         card_s2_r;

   wire        stage_relay_one = stage_r[0];
   wire [7:0]  en_all = {en58_r, en24_r[3:1], 1'b1};
   wire        is_fix = (mode_r >= `MODE_FIX_LOFF) && (mode_r <= `MODE_FIX_FOFF);
   wire        is_cyc = (mode_r == `MODE_CYC_ALL) || (mode_r == `MODE_CYC_INV);
   wire        is_brd = (mode_r == `MODE_CYC_BOARD);
   wire        inv_only = (mode_r == `MODE_FIX_INV) || (mode_r == `MODE_CYC_INV);
   wire        active = (mode_r != `MODE_OFF) && (src_r || card_s2_r);

   // Thresholds pulled inward by the bias
   wire [FW-1:0] up_th = (upper_lim > bias_r[FW-1:0]) ?
                         upper_lim - bias_r[FW-1:0] : {FW{1'b0}};
   wire [FW-1:0] lo_th = lower_lim + bias_r[FW-1:0];
   wire          at_hi = (fout >= up_th);
   wire          at_lo = (fout <= lo_th);
   wire          up_done;
   wire          lo_done;
   wire          dwell_clr = (st_r != S_RUN);

   // -----------------------------------------
   // Dwell timers
   // -----------------------------------------
   dwell_timer #(.W(17)) up_tmr
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (dwell_clr),
      .in_band (at_hi),
      .tick    (tick_r),
      .limit   (up_t_r * `DWELL_SCALE),
      .done_r  (up_done)
   );

   dwell_timer #(.W(17)) lo_tmr
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (dwell_clr),
      .in_band (at_lo),
      .tick    (tick_r),
      .limit   (lo_t_r * `DWELL_SCALE),
      .done_r  (lo_done)
   );

   // -----------------------------------------
   // Relay choice
   // -----------------------------------------
   reg [2:0] top_idx;     // Highest relay usable as a lag pump
   reg [2:0] add_idx;
   reg       add_ok;
   reg [2:0] rem_idx;
   reg       rem_ok;
   reg [1:0] rem_pair;
   reg       pair_ok;
   integer   i;

   // Next relay to add and last one to shed
   always @*
   begin
      top_idx  = src_r ? `FIX_BOARD_TOP : `FIX_CARD_TOP;
      add_idx  = 3'h0;
      add_ok   = 1'b0;
      rem_idx  = 3'h0;
      rem_ok   = 1'b0;
      rem_pair = 2'h0;
      // Scan downward so the lowest free relay wins
      for (i = 7; i >= 1; i = i - 1)
      begin
         if (i <= top_idx && en_all[i] && !stage_r[i])
         begin
            add_idx = i[2:0];
            add_ok  = 1'b1;
         end
      end
      for (i = 1; i <= 7; i = i + 1)
      begin
         // Last on is the highest unless first on, first off
         if (stage_r[i] && (mode_r != `MODE_FIX_FOFF || !rem_ok))
         begin
            rem_idx = i[2:0];              // Lead relay never chosen
            rem_ok  = 1'b1;
         end
      end
      // Card cycle: oldest pair on mains goes first
      for (i = 3; i >= 0; i = i - 1)
      begin
         if (stage_r[2*i+1])
         begin
            rem_pair = i[1:0];
         end
      end
      // Next pair only when both its relays are enabled
      pair_ok = (cur_r < `CYC_CARD_PAIRS) &&
                en_all[{cur_r + 2'h1, 1'b0}] && en_all[{cur_r + 2'h1, 1'b1}];
   end

   // -----------------------------------------
   // Tick divider
   // -----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_cnt_r <= 22'h000000;
         tick_r     <= 1'b0;
      end
      else if (tick_cnt_r == TICK_CYCLES[21:0] - 22'h000001)
      begin
         tick_cnt_r <= 22'h000000;
         tick_r     <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 22'h000001;
         tick_r     <= 1'b0;
      end
   end

   // -----------------------------------------
   // Card presence synchroniser
   // -----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         card_s1_r <= 1'b0;
         card_s2_r <= 1'b0;
      end
      else
      begin
         card_s1_r <= card_present;
         card_s2_r <= card_s1_r;
      end
   end

   // -----------------------------------------
   // Sequencer
   // -----------------------------------------
   // A new command from the dwell timers is only taken in S_RUN, so a
   // transfer always finishes before the next decision
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r       <= S_IDLE;
         stage_r    <= 8'h00;
         cur_r      <= 2'h0;
         wait_r     <= 17'h00000;
         inv_out_en <= 1'b0;
         pid_hold   <= 1'b0;
         ramp_up    <= 1'b0;
         ramp_down  <= 1'b0;
      end
      else if (!run_cmd || !active)
      begin
         st_r       <= S_IDLE;
         inv_out_en <= 1'b0;
         pid_hold   <= 1'b0;
         ramp_up    <= 1'b0;
         ramp_down  <= 1'b0;
         // Lag pumps on mains stay only in inverter-only stop
         if (inv_only && active)
         begin
            stage_r <= is_cyc ? (stage_r & 8'hAA) : (stage_r & 8'hFE);
         end
         else
         begin
            stage_r <= 8'h00;
         end
      end
      else
      begin
         if (tick_r && wait_r != 17'h00000)
         begin
            wait_r <= wait_r - 17'h00001;
         end
         case (st_r)
            S_IDLE:
            begin
               // Lead pump on the inverter, relay one always used
               stage_r[0] <= 1'b1;
               cur_r      <= 2'h0;
               inv_out_en <= 1'b1;
               st_r       <= S_RUN;
            end
            S_RUN:
            begin
               if (up_done && is_cyc && pair_ok)
               begin
                  stage_r[{cur_r, 1'b0}] <= 1'b0;
                  inv_out_en <= 1'b0;
                  wait_r     <= {1'b0, mc_t_r};
                  st_r       <= S_XOFF;
               end
               else if (up_done && is_brd && add_ok)
               begin
                  inv_out_en       <= 1'b0;
                  stage_r[add_idx] <= 1'b1;
                  wait_r     <= {mc_t_r, 1'b0};           // Twice the delay
                  st_r       <= S_XON;
               end
               else if (up_done && is_fix && add_ok)
               begin
                  stage_r[add_idx] <= 1'b1;
                  pid_hold   <= 1'b1;
                  ramp_down  <= 1'b1;
                  st_r       <= S_RLO;
               end
               else if (lo_done && is_cyc && stage_r != 8'h01 &&
                        (stage_r & 8'hAA) != 8'h00)
               begin
                  stage_r[{rem_pair, 1'b1}] <= 1'b0;
                  pid_hold   <= 1'b1;
                  ramp_up    <= 1'b1;
                  st_r       <= S_RHI;
               end
               else if (lo_done && !is_cyc && rem_ok)
               begin
                  stage_r[rem_idx] <= 1'b0;
                  pid_hold   <= 1'b1;
                  ramp_up    <= 1'b1;
                  st_r       <= S_RHI;
               end
            end
            S_RLO:
            begin
               if (fout <= lower_lim)
               begin
                  pid_hold  <= 1'b0;
                  ramp_down <= 1'b0;
                  st_r      <= S_RUN;
               end
            end
            S_RHI:
            begin
               if (fout >= upper_lim)
               begin
                  pid_hold <= 1'b0;
                  ramp_up  <= 1'b0;
                  st_r     <= S_RUN;
               end
            end
            S_XOFF:
            begin
               if (wait_r == 17'h00000)
               begin
                  // Old motor to mains, next motor to inverter
                  stage_r[{cur_r, 1'b1}]        <= 1'b1;
                  stage_r[{cur_r + 2'h1, 1'b0}] <= 1'b1;
                  cur_r  <= cur_r + 2'h1;
                  wait_r <= {1'b0, mc_t_r};
                  st_r   <= S_XON;
               end
            end
            S_XON:
            begin
               if (wait_r == 17'h00000)
               begin
                  inv_out_en <= 1'b1;
                  st_r       <= S_RUN;
               end
            end
            default:
            begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------
   // Relay outputs
   // -----------------------------------------
   // Board relays follow staging only when the board is the source
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         card_relay            <= 8'h00;
         board_relay_out_one   <= 1'b0;
         board_relay_out_two   <= 1'b0;
         board_relay_out_three <= 1'b0;
      end
      else if (src_r == `SRC_BOARD && mode_r != `MODE_OFF)
      begin
         card_relay            <= 8'h00;
         board_relay_out_one   <= stage_relay_one;
         board_relay_out_two   <= stage_r[1];
         board_relay_out_three <= stage_r[2];
      end
      else
      begin
         card_relay            <= card_s2_r ? stage_r : 8'h00;
         board_relay_out_one   <= gen_relay_func[0];
         board_relay_out_two   <= gen_relay_func[1];
         board_relay_out_three <= gen_relay_func[2];
      end
   end

   // -----------------------------------------
   // Register write path
   // -----------------------------------------
   wire [31:0] bmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                        {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire [31:0] ctrl_old = {20'h00000, en58_r, en24_r, src_r, mode_r};
   wire [31:0] ctrl_new = (ctrl_old & ~bmask) | (w_data_r & bmask);
   wire [2:0]  nmode = ctrl_new[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
   wire        nsrc  = ctrl_new[`CTRL_SRC_BIT];
   // Modes 4 and 5 need the card, mode 6 needs the board
   wire        mode_ok = (nmode <= `MODE_CYC_BOARD) &&
                         (nsrc ? (nmode <= `MODE_FIX_FOFF || nmode == `MODE_CYC_BOARD)
                               : (nmode != `MODE_CYC_BOARD));

   // Merge byte lanes into a 16-bit setting and clamp it
   function [15:0] merge_clamp;
      input [15:0] old;
      input [31:0] d;
      input [31:0] m;
      input [15:0] lo;
      input [15:0] hi;
      reg   [15:0] v;
      begin
         v = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
         merge_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   wire do_wr = aw_full_r && w_full_r && !bvalid;

   // Write handshake, one write at a time
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= 2'b00;
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h00000000;
         w_strb_r  <= 4'h0;
         mode_r    <= `MODE_OFF;
         src_r     <= `SRC_CARD;
         en24_r    <= 4'h0;
         en58_r    <= 4'h0;
         up_t_r    <= `DWELL_MIN;
         lo_t_r    <= `DWELL_MIN;
         mc_t_r    <= `MC_MIN;
         bias_r    <= 16'h0000;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= awaddr;
            awready   <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_full_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
            wready   <= 1'b0;
         end
         if (bvalid && bready)
         begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         if (do_wr)
         begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= 2'b00;
            if (aw_addr_r == `REG_CTRL)
            begin
               if (mode_ok)
               begin
                  mode_r <= nmode;
               end
               src_r  <= nsrc;
               // Reserved low bit, relay 4 and 5-8 forced off on board
               en24_r <= {ctrl_new[`CTRL_EN24_MSB] & ~nsrc,
                          ctrl_new[`CTRL_EN24_MSB-1:`CTRL_EN24_LSB+1],
                          1'b0};
               en58_r <= nsrc ? 4'h0 :
                         ctrl_new[`CTRL_EN58_MSB:`CTRL_EN58_LSB];
            end
            else if (aw_addr_r == `REG_UP_TIME)
            begin
               up_t_r <= merge_clamp(up_t_r, w_data_r, bmask,
                                     `DWELL_MIN, `DWELL_MAX);
            end
            else if (aw_addr_r == `REG_LO_TIME)
            begin
               lo_t_r <= merge_clamp(lo_t_r, w_data_r, bmask,
                                     `DWELL_MIN, `DWELL_MAX);
            end
            else if (aw_addr_r == `REG_MC_TIME)
            begin
               mc_t_r <= merge_clamp(mc_t_r, w_data_r, bmask,
                                     `MC_MIN, `MC_MAX);
            end
            else if (aw_addr_r == `REG_BIAS)
            begin
               bias_r <= merge_clamp(bias_r, w_data_r, bmask,
                                     16'h0000, `BIAS_MAX);
            end
            else if (aw_addr_r != `REG_STATUS)
            begin
               bresp <= 2'b10;                            // Unmapped
            end
         end
      end
   end

   // -----------------------------------------
   // Register read path
   // -----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rresp   <= 2'b00;
         rdata   <= 32'h00000000;
      end
      else if (rvalid)
      begin
         if (rready)
         begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= 2'b00;
         if (araddr == `REG_CTRL)
         begin
            rdata <= ctrl_old;
         end
         else if (araddr == `REG_UP_TIME)
         begin
            rdata <= {16'h0000, up_t_r};
         end
         else if (araddr == `REG_LO_TIME)
         begin
            rdata <= {16'h0000, lo_t_r};
         end
         else if (araddr == `REG_MC_TIME)
         begin
            rdata <= {16'h0000, mc_t_r};
         end
         else if (araddr == `REG_BIAS)
         begin
            rdata <= {16'h0000, bias_r};
         end
         else if (araddr == `REG_STATUS)
         begin
            rdata <= {16'h0000, card_s2_r, ramp_up, ramp_down, pid_hold,
                      inv_out_en, st_r, stage_r};
         end
         else
         begin
            rdata <= 32'h00000000;
            rresp <= 2'b10;
         end
      end
   end

endmodule

`default_nettype wire

// *** pkg/staging_map.vh ***
`ifndef STAGING_MAP_VH
`define STAGING_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_UP_TIME     8'h04
`define REG_LO_TIME     8'h08
`define REG_MC_TIME     8'h0C
`define REG_BIAS        8'h10
`define REG_STATUS      8'h14

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   2
`define CTRL_SRC_BIT    3
`define CTRL_EN24_LSB   4
`define CTRL_EN24_MSB   7
`define CTRL_EN58_LSB   8
`define CTRL_EN58_MSB   11

// ----------------------------------------
// Staging modes and sources
// ----------------------------------------
`define MODE_OFF        3'h0
`define MODE_FIX_LOFF   3'h1
`define MODE_FIX_INV    3'h2
`define MODE_FIX_FOFF   3'h3
`define MODE_CYC_ALL    3'h4
`define MODE_CYC_INV    3'h5
`define MODE_CYC_BOARD  3'h6
`define SRC_CARD        1'b0
`define SRC_BOARD       1'b1

// ----------------------------------------
// Ranges, in 0.1 s, 0.01 s and 0.1 %
// ----------------------------------------
`define DWELL_MIN       16'h000A
`define DWELL_MAX       16'h1770
`define MC_MIN          16'h000A
`define MC_MAX          16'h00C8
`define BIAS_MAX        16'h00C8
`define DWELL_SCALE     17'h0000A

// ----------------------------------------
// Pump limits as highest usable relay index, and highest pair index in card cycle
// ----------------------------------------
`define FIX_CARD_TOP    3'h7
`define FIX_BOARD_TOP   3'h2
`define CYC_CARD_PAIRS  2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS          4
`define TICK_NS         10000000

`endif

// *** testbench/contactor_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Contactors close two cycles late but open at once
module contactor_model (
   input  wire logic       aclk,
   input  wire logic [7:0] relay,
   output logic      [7:0] closed
);
   logic [7:0] d1_r;
   logic [7:0] d2_r;
   always_ff @(posedge aclk)
   begin
      d1_r <= relay;
      d2_r <= d1_r;
   end
   assign closed = relay & d1_r & d2_r;
endmodule
`default_nettype wire

// *** testbench/multi_pump_staging_sequencer_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module multi_pump_staging_sequencer_tb_top;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic run_cmd = 0, card_present = 1, awready, wready, bvalid, arready, rvalid;
   logic b1, b2, b3, inv_out_en, pid_hold, ramp_up, ramp_down;
   logic [7:0] awaddr = 0, araddr = 0, card_relay, closed;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 4'hF;
   logic [2:0] gen_relay_func = 3'h5;
   logic [1:0] bresp, rresp, r;
   logic [15:0] fout = 0, upper_lim = 16'h0320, lower_lim = 16'h00C8;
   int errors = 0, n_tests = 0, c;
   typedef struct packed {logic [7:0] a; logic [31:0] w, e; logic [1:0] s;} row_t;
   // Address, write data, read back, response; board source refuses mode 4
   row_t rows [9] = '{'{8'h04, 0, 32'h0A, 0}, '{8'h04, 32'hFFFF, 32'h1770, 0},
      '{8'h08, 5, 32'h0A, 0}, '{8'h0C, 1, 32'h0A, 0}, '{8'h0C, 32'h3E8, 32'hC8, 0},
      '{8'h10, 32'h3E8, 32'hC8, 0}, '{8'h00, 32'hF1, 32'hE1, 0},
      '{8'h00, 32'hFC, 32'h69, 0}, '{8'h40, 1, 0, 2'h2}};
   initial forever #2 aclk = ~aclk;
   pump_staging #(.TICK_CYCLES(10)) i_pump_staging (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .fout(fout), .upper_lim(upper_lim),
      .lower_lim(lower_lim), .run_cmd(run_cmd), .card_present(card_present),
      .gen_relay_func(gen_relay_func), .card_relay(card_relay), .board_relay_out_one(b1),
      .board_relay_out_two(b2), .board_relay_out_three(b3), .inv_out_en(inv_out_en),
      .pid_hold(pid_hold), .ramp_up(ramp_up), .ramp_down(ramp_down));
   contactor_model i_contactor_model (.aclk(aclk), .relay(card_relay), .closed(closed));
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Write: each channel released as taken, bready held until bvalid
   task wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] s);
      int i;
      @(posedge aclk);
      awaddr <= a; wdata <= w; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      s = bresp; bready <= 0;
      if (i == 50)
      begin
         chk(0, 1);
         end_sim;
      end
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
      int i;
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      v = rdata; s = rresp; rready <= 0;
      if (i == 50)
      begin
         chk(0, 1);
         end_sim;
      end
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      repeat (4) @(posedge aclk);
      chk({b3, b2, b1}, 3'h5);
      foreach (rows[k])
      begin
         wr(rows[k].a, rows[k].w, r);
         chk(r, rows[k].s);
         rd(rows[k].a, d, r);
         chk(r, rows[k].s);
         chk(d, rows[k].e);
      end
      $display("register table done");
      wr(8'h00, 32'h0E, r);
      run_cmd <= 1;
      repeat (6) @(posedge aclk);
      chk({b3, b2, b1}, 3'h1);
      run_cmd <= 0;
      wr(8'h10, 32'h32, r);
      wr(8'h04, 32'h0A, r);
      wr(8'h08, 32'h0A, r);
      wr(8'h00, 32'hE1, r);
      fout <= 16'h02EE; run_cmd <= 1;
      for (c = 0; c < 3000 && card_relay[1] !== 1; c++) @(posedge aclk);
      chk(c > 990 && c < 1300, 1);
      repeat (2) @(posedge aclk);
      chk({card_relay, pid_hold, ramp_down, ramp_up}, {8'h03, 3'h6});
      fout <= lower_lim;
      repeat (4) @(posedge aclk);
      chk({pid_hold, ramp_down}, 0);
      fout <= 16'h00FA;
      repeat (500) @(posedge aclk);
      fout <= 16'h0190;
      repeat (4) @(posedge aclk);
      fout <= 16'h00FA;
      for (c = 0; c < 3000 && card_relay[1] !== 0; c++) @(posedge aclk);
      chk(c > 990 && c < 1300, 1);
      repeat (2) @(posedge aclk);
      chk({card_relay, inv_out_en, pid_hold, ramp_up}, {8'h01, 3'h7});
      chk(closed[1:0], 2'h1);
      run_cmd <= 0;
      repeat (4) @(posedge aclk);
      chk({card_relay, inv_out_en}, 0);
      $display("staging sequence done");
      // Card cycle, inverter-only stop, pair on relays 3 and 4
      wr(8'h0C, 32'h0A, r);
      wr(8'h00, 32'hE5, r);
      fout <= 16'h02EE; run_cmd <= 1;
      repeat (4) @(posedge aclk);
      chk({card_relay, inv_out_en}, {8'h01, 1'b1});
      for (c = 0; c < 3000 && card_relay[0] !== 0; c++) @(posedge aclk);
      chk({c > 980 && c < 1300, card_relay, inv_out_en}, {1'b1, 9'h000});
      for (c = 0; c < 300 && card_relay !== 8'h06; c++) @(posedge aclk);
      chk({c > 80 && c < 120, inv_out_en}, 2'h2);
      for (c = 0; c < 300 && inv_out_en !== 1; c++) @(posedge aclk);
      chk(c > 80 && c < 120, 1);
      run_cmd <= 0;
      repeat (4) @(posedge aclk);
      chk({card_relay, inv_out_en}, {8'h02, 1'b0});
      $display("cycle transfer done");
      end_sim;
   end
endmodule
`default_nettype wire

// *** testbench/staging_chk_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module staging_chk (
   input wire logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
   input wire logic arvalid, arready, rvalid, rready, run_cmd, inv_out_en,
   input wire logic pid_hold, ramp_up, ramp_down
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
   a_r_hold: assert property (rvalid && !rready |=> rvalid) else $error("rvalid dropped");
   a_ar_block: assert property (rvalid |-> !arready) else $error("arready during rvalid");
   a_aw_block: assert property (bvalid |-> !awready && !wready) else $error("ready in resp");
   a_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
   a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("no write answer");
   a_ramp_excl: assert property (!(ramp_up && ramp_down)) else $error("two ramps");
   a_ramp_hold: assert property (ramp_up || ramp_down |-> pid_hold) else $error("loop on");
   a_stop_off: assert property (!run_cmd [*3] |-> !inv_out_en) else $error("inv on");
   c_write: cover property ($rose(bvalid));
   c_ramp_dn: cover property ($rose(ramp_down));
   c_ramp_up: cover property ($rose(ramp_up));
endmodule
bind pump_staging staging_chk i_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .run_cmd(run_cmd),
   .inv_out_en(inv_out_en), .pid_hold(pid_hold), .ramp_up(ramp_up), .ramp_down(ramp_down));
`default_nettype wire
